// [pkg/flash_ctrl_consts.svh]
`ifndef FLASH_CTRL_CONSTS_SVH
`define FLASH_CTRL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_TARGET_ADDR 9'h000
`define OFS_WRITE_DATA 9'h004
`define OFS_COMMAND 9'h008
`define OFS_RAW_STATUS 9'h00C
`define OFS_INT_MASK 9'h010
`define OFS_MASKED_STATUS 9'h014
`define OFS_READ_PROTECT 9'h130
`define OFS_PROG_PROTECT 9'h134
`define OFS_TICK_RELOAD 9'h140

// ----------------------------------------
// Command register fields
// ----------------------------------------
`define WRITE_KEY 16'hA442
`define CMD_WRITE 0
`define CMD_ERASE 1
`define CMD_MERASE 2
`define CMD_COMMIT 3

// ----------------------------------------
// Status and mask fields
// ----------------------------------------
`define ST_ACCESS 0
`define ST_DONE 1

// ----------------------------------------
// Reset and erased values
// ----------------------------------------
`define RST_TICK_RELOAD 8'h31
`define RST_PROTECT 32'hFFFF_FFFF
`define ERASED_WORD 32'hFFFF_FFFF

// ----------------------------------------
// Pulse lengths in microsecond ticks
// ----------------------------------------
`define PROG_PULSE_US 24'h00_0014
`define PAGE_ERASE_US 24'h00_4E20
`define MASS_ERASE_US 24'h03_0D40

`endif

// [pkg/flash_ctrl_pkg.sv]
package flash_ctrl_pkg;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PULSE,
      ST_COMMIT
   } seq_state_t;

   typedef struct packed {
      logic [7:0] tick_cnt;
      logic [23:0] us_left;
      logic busy;
      logic done;
   } timer_state_t;

   typedef struct packed {
      logic loaded;
      logic [31:0] pe;
      logic [31:0] re;
   } prot_state_t;

   typedef struct packed {
      seq_state_t st;
      logic [15:0] target_addr;
      logic [31:0] write_data;
      logic [3:0] cmd;
      logic [7:0] tick_reload;
      logic [1:0] raw;
      logic [1:0] mask;
      logic [31:0] reg_rdata;
      logic arr_rd;
      logic [15:0] arr_raddr;
      logic rd1;
      logic rd1_block;
      logic rd2;
      logic rd2_block;
      logic rvalid;
      logic [31:0] rdata;
      logic [15:0] op_addr;
      logic [31:0] op_data;
      logic commit_pe;
   } ctrl_state_t;

endpackage : flash_ctrl_pkg

// [pkg/usec_timer_if.sv]
`timescale 1ns/1ps
interface usec_timer_if;
   logic [7:0] reload;
   logic start;
   logic [23:0] us_count;
   logic busy;
   logic done;
   modport ctrl (output reload, output start, output us_count, input busy, input done);
   modport timer (input reload, input start, input us_count, output busy, output done);
endinterface : usec_timer_if

// [core/usec_timer.sv]
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module usec_timer (
   input wire logic clk, // System clock
   input wire logic rst_n, // Synchronised reset
   usec_timer_if.timer tif // Reload and pulse request
);
   flash_ctrl_pkg::timer_state_t s, next_s;
   logic tick;

   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      tick = (s.tick_cnt == 8'h00);
      // Divider reloads every microsecond so a new rate applies at the next tick
      if (tick) begin
         next_s.tick_cnt = tif.reload;
      end else begin
         next_s.tick_cnt = s.tick_cnt - 8'h01;
      end
      if (tif.start) begin
         next_s.busy = 1'b1;
         next_s.us_left = tif.us_count;
         next_s.tick_cnt = tif.reload;
      end else if (s.busy && tick) begin
         if (s.us_left <= 24'h00_0001) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.us_left = s.us_left - 24'h00_0001;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tif.busy = s.busy;
   assign tif.done = s.done;

   tick_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
      (tick && !tif.start) |=> (s.tick_cnt == $past(tif.reload)))
      else $error("Tick divider did not reload");
endmodule : usec_timer

// [core/prot_regs.sv]
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module prot_regs (
   input wire logic clk, // System clock
   input wire logic rst_n, // Synchronised reset
   input wire logic [31:0] nv_pe, // Committed program enables
   input wire logic [31:0] nv_re, // Committed read enables
   input wire logic wr_pe, // Write to program enables
   input wire logic wr_re, // Write to read enables
   input wire logic [31:0] wdata, // Write data
   output logic loaded, // Committed values taken
   output logic [31:0] program_enable_protect_bits, // Working program enables
   output logic [31:0] read_enable_protect_bits // Working read enables
);
   flash_ctrl_pkg::prot_state_t s, next_s;

   always_comb begin
      next_s = s;
      if (!s.loaded) begin
         // Uncommitted clears vanish: working copy comes back from the store
         next_s.loaded = 1'b1;
         next_s.pe = nv_pe;
         next_s.re = nv_re;
      end else begin
         if (wr_pe) begin
            next_s.pe = s.pe & wdata;
         end
         if (wr_re) begin
            next_s.re = s.re & wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= {1'b0, `RST_PROTECT, `RST_PROTECT};
      end else begin
         s <= next_s;
      end
   end

   assign loaded = s.loaded;
   assign program_enable_protect_bits = s.pe;
   assign read_enable_protect_bits = s.re;

   rw0_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      s.loaded |=> ((s.pe & ~$past(s.pe)) == 32'h0000_0000) && ((s.re & ~$past(s.re)) == 32'h0000_0000))
      else $error("Protection bit rose after load");
endmodule : prot_regs

// [core/flash_protect_program_ctrl.sv]
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_protect_program_ctrl (
   input wire logic clk, // 20 MHz system clock
   input wire logic resetn, // Power-on reset, active low
   input wire logic [8:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [31:0] reg_rdata, // Read data, cycle after strobe
   input wire logic cpu_rd, // Read request from the code bus
   input wire logic cpu_fetch, // Request is an instruction fetch
   input wire logic [15:0] cpu_addr, // Byte address of the read
   output logic cpu_rvalid, // Read answer valid
   output logic [31:0] cpu_rdata, // Read answer data
   output logic arr_rd, // Array read strobe
   output logic [15:0] arr_raddr, // Array read address
   input wire logic [31:0] arr_rdata, // Array data, cycle after strobe
   output logic arr_prog, // Word program pulse
   output logic arr_erase_page, // Page erase pulse
   output logic arr_erase_mass, // Mass erase pulse
   output logic [15:0] arr_addr, // Program or erase address
   output logic [31:0] arr_wdata, // Program data
   input wire logic [31:0] nv_pe, // Committed program enables
   input wire logic [31:0] nv_re, // Committed read enables
   output logic nv_commit, // Commit strobe
   output logic nv_commit_pe, // Commit selects program enables
   output logic [31:0] nv_commit_data, // Value to commit
   output logic ctrl_irq // Controller interrupt
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic [1:0] rst_sync;
   logic rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   usec_timer_if tif ();
   logic prot_loaded;
   logic [31:0] pe;
   logic [31:0] re;
   logic wr_pe;
   logic wr_re;

   usec_timer u_timer (
      .clk(clk),
      .rst_n(rst_n),
      .tif(tif.timer)
   );

   prot_regs u_prot (
      .clk(clk),
      .rst_n(rst_n),
      .nv_pe(nv_pe),
      .nv_re(nv_re),
      .wr_pe(wr_pe),
      .wr_re(wr_re),
      .wdata(reg_wdata),
      .loaded(prot_loaded),
      .program_enable_protect_bits(pe),
      .read_enable_protect_bits(re)
   );

   // ----------------------------------------
   // Control state
   // ----------------------------------------
   flash_ctrl_pkg::ctrl_state_t s, next_s;
   logic key_wr;
   logic [4:0] op_unit;
   logic [4:0] rd_unit;
   logic program_protected;
   logic read_protected;
   logic start;
   logic [23:0] start_us;

   assign wr_pe = reg_wr && (reg_addr == `OFS_PROG_PROTECT);
   assign wr_re = reg_wr && (reg_addr == `OFS_READ_PROTECT);
   assign key_wr = reg_wr && (reg_addr == `OFS_COMMAND) && (reg_wdata[31:16] == `WRITE_KEY);
   // Unit index is address bits above the 2 KB boundary
   assign op_unit = s.target_addr[15:11];
   assign rd_unit = cpu_addr[15:11];
   assign program_protected = !pe[op_unit];
   assign read_protected = !re[rd_unit];

   always_comb begin
      next_s = s;
      start = 1'b0;
      start_us = `PROG_PULSE_US;
      next_s.reg_rdata = 32'h0000_0000;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `OFS_TARGET_ADDR: next_s.target_addr = reg_wdata[15:0];
            `OFS_WRITE_DATA: next_s.write_data = reg_wdata;
            `OFS_INT_MASK: next_s.mask = reg_wdata[1:0];
            `OFS_MASKED_STATUS: next_s.raw = s.raw & ~reg_wdata[1:0];
            `OFS_TICK_RELOAD: next_s.tick_reload = reg_wdata[7:0];
            default: ;
         endcase
      end

      // Sequencer
      case (s.st)
         flash_ctrl_pkg::ST_IDLE: begin
            // Multiple command bits: lowest one wins
            if (key_wr && prot_loaded) begin
               if (reg_wdata[`CMD_COMMIT] && !(|reg_wdata[2:0])) begin
                  next_s.cmd = 4'b1000;
                  next_s.commit_pe = s.target_addr[0];
                  next_s.st = flash_ctrl_pkg::ST_COMMIT;
               end else if (reg_wdata[`CMD_WRITE] || reg_wdata[`CMD_ERASE]) begin
                  if (program_protected) begin
                     next_s.raw[`ST_ACCESS] = 1'b1;
                     next_s.cmd = 4'b0000;
                  end else begin
                     start = 1'b1;
                     next_s.st = flash_ctrl_pkg::ST_PULSE;
                     if (reg_wdata[`CMD_WRITE]) begin
                        next_s.cmd = 4'b0001;
                        next_s.op_addr = {s.target_addr[15:2], 2'b00};
                        next_s.op_data = s.write_data;
                     end else begin
                        next_s.cmd = 4'b0010;
                        next_s.op_addr = {s.target_addr[15:10], 10'h000};
                        next_s.op_data = `ERASED_WORD;
                        start_us = `PAGE_ERASE_US;
                     end
                  end
               end else if (reg_wdata[`CMD_MERASE]) begin
                  // Mass erase refused while any unit is program protected
                  if (pe != `RST_PROTECT) begin
                     next_s.raw[`ST_ACCESS] = 1'b1;
                     next_s.cmd = 4'b0000;
                  end else begin
                     start = 1'b1;
                     start_us = `MASS_ERASE_US;
                     next_s.cmd = 4'b0100;
                     next_s.op_addr = 16'h0000;
                     next_s.op_data = `ERASED_WORD;
                     next_s.st = flash_ctrl_pkg::ST_PULSE;
                  end
               end
            end
         end
         flash_ctrl_pkg::ST_PULSE: begin
            if (tif.done) begin
               next_s.cmd = 4'b0000;
               next_s.raw[`ST_DONE] = 1'b1;
               next_s.st = flash_ctrl_pkg::ST_IDLE;
            end
         end
         flash_ctrl_pkg::ST_COMMIT: begin
            next_s.cmd = 4'b0000;
            next_s.st = flash_ctrl_pkg::ST_IDLE;
         end
         default: next_s.st = flash_ctrl_pkg::ST_IDLE;
      endcase

      // Code bus read pipeline: request, array, answer
      next_s.arr_rd = cpu_rd;
      next_s.arr_raddr = cpu_addr;
      next_s.rd1 = cpu_rd;
      next_s.rd1_block = cpu_rd && !cpu_fetch && read_protected;
      next_s.rd2 = s.rd1;
      next_s.rd2_block = s.rd1_block;
      next_s.rvalid = s.rd2;
      next_s.rdata = s.rd2_block ? 32'h0000_0000 : arr_rdata;
      if (s.rd2 && s.rd2_block) begin
         next_s.raw[`ST_ACCESS] = 1'b1;
      end

      // Register reads
      if (reg_rd) begin
         case (reg_addr)
            `OFS_TARGET_ADDR: next_s.reg_rdata = {16'h0000, s.target_addr};
            `OFS_WRITE_DATA: next_s.reg_rdata = s.write_data;
            `OFS_COMMAND: next_s.reg_rdata = {28'h000_0000, s.cmd};
            `OFS_RAW_STATUS: next_s.reg_rdata = {30'h0000_0000, s.raw};
            `OFS_INT_MASK: next_s.reg_rdata = {30'h0000_0000, s.mask};
            `OFS_MASKED_STATUS: next_s.reg_rdata = {30'h0000_0000, s.raw & s.mask};
            `OFS_READ_PROTECT: next_s.reg_rdata = re;
            `OFS_PROG_PROTECT: next_s.reg_rdata = pe;
            `OFS_TICK_RELOAD: next_s.reg_rdata = {24'h00_0000, s.tick_reload};
            default: next_s.reg_rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.st <= flash_ctrl_pkg::ST_IDLE;
         s.tick_reload <= `RST_TICK_RELOAD;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign tif.reload = s.tick_reload;
   assign tif.start = start;
   assign tif.us_count = start_us;

   assign reg_rdata = s.reg_rdata;
   assign cpu_rvalid = s.rvalid;
   assign cpu_rdata = s.rdata;
   assign arr_rd = s.arr_rd;
   assign arr_raddr = s.arr_raddr;
   assign arr_addr = s.op_addr;
   assign arr_wdata = s.op_data;
   assign arr_prog = (s.st == flash_ctrl_pkg::ST_PULSE) && s.cmd[`CMD_WRITE];
   assign arr_erase_page = (s.st == flash_ctrl_pkg::ST_PULSE) && s.cmd[`CMD_ERASE];
   assign arr_erase_mass = (s.st == flash_ctrl_pkg::ST_PULSE) && s.cmd[`CMD_MERASE];
   assign nv_commit = (s.st == flash_ctrl_pkg::ST_COMMIT);
   assign nv_commit_pe = s.commit_pe;
   assign nv_commit_data = s.commit_pe ? pe : re;
   assign ctrl_irq = |(s.raw & s.mask);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   key_guard_a: assert property ($rose(arr_prog || arr_erase_page || arr_erase_mass) |-> $past(key_wr))
      else $error("Operation started without key");
   prot_block_a: assert property ((arr_prog || arr_erase_page) |-> pe[arr_addr[15:11]])
      else $error("Protected unit being changed");
   blocked_viol_a: assert property ((s.st == flash_ctrl_pkg::ST_IDLE) && key_wr && prot_loaded
      && (reg_wdata[2:0] == 3'b001) && program_protected |=> s.raw[`ST_ACCESS] && (s.cmd == 4'b0000)
      && (s.st == flash_ctrl_pkg::ST_IDLE))
      else $error("Blocked write not flagged");
   read_zero_a: assert property (cpu_rd && !cpu_fetch && read_protected |-> ##3 (cpu_rvalid && cpu_rdata == 32'h0000_0000))
      else $error("Protected data read leaked");
   read_flag_a: assert property (cpu_rd && !cpu_fetch && read_protected |-> ##3 s.raw[`ST_ACCESS])
      else $error("Read violation not flagged");
   fetch_pass_a: assert property (cpu_rd && cpu_fetch |-> ##3 (cpu_rvalid && cpu_rdata == $past(arr_rdata)))
      else $error("Fetch data not passed");
   // The timer drops busy in the cycle it reports done, while the sequencer is still in the pulse state
   busy_bit_a: assert property ((s.st == flash_ctrl_pkg::ST_PULSE) |-> (s.cmd != 4'b0000) && (tif.busy || tif.done))
      else $error("Command bit clear while busy");
   done_clear_a: assert property ((s.st == flash_ctrl_pkg::ST_PULSE) && tif.done |=> (s.cmd == 4'b0000)
      && s.raw[`ST_DONE])
      else $error("Command bit not cleared at end");
   erase_ones_a: assert property ((arr_erase_page || arr_erase_mass) |-> (arr_wdata == `ERASED_WORD))
      else $error("Erase data not all ones");
   page_align_a: assert property (arr_erase_page |-> (arr_addr[9:0] == 10'h000))
      else $error("Page erase address not aligned");

   prog_cov: cover property ($rose(arr_prog) ##[1:1000] $fell(arr_prog));
   erase_cov: cover property ($rose(arr_erase_page));
   read_block_cov: cover property (cpu_rvalid && s.raw[`ST_ACCESS]);
   commit_cov: cover property (nv_commit);
endmodule : flash_protect_program_ctrl

// [tb/flash_array_model.sv]
`timescale 1ns/1ps
module flash_array_model (
   input wire logic clk, // System clock
   input wire logic arr_rd, // Read strobe
   input wire logic [15:0] arr_raddr, // Read address
   output logic [31:0] arr_rdata, // Read data
   input wire logic arr_prog, // Program pulse
   input wire logic arr_erase_page, // Page erase pulse
   input wire logic arr_erase_mass, // Mass erase pulse
   input wire logic [15:0] arr_addr, // Target address
   input wire logic [31:0] arr_wdata, // Program data
   input wire logic nv_commit, // Commit strobe
   input wire logic nv_commit_pe, // Commit selects program enables
   input wire logic [31:0] nv_commit_data, // Commit value
   output logic [31:0] nv_pe, // Stored program enables
   output logic [31:0] nv_re // Stored read enables
);
   logic [31:0] mem [0:16383];
   logic prog_q, erase_q, mass_q;
   initial begin
      for (int i = 0; i < 16384; i++)
         mem[i] = 32'hFFFF_FFFF;
      arr_rdata = 32'h0000_0000;
      nv_pe = 32'hFFFF_FFFF;
      nv_re = 32'hFFFF_FFFF;
   end
   // ----------------------------------------
   // Array and store behaviour
   // ----------------------------------------
   always @(posedge clk) begin
      prog_q <= arr_prog;
      erase_q <= arr_erase_page;
      mass_q <= arr_erase_mass;
      // Data in the cycle after a strobe; without a strobe the previous output inverts every cycle
      arr_rdata <= arr_rd ? mem[arr_raddr[15:2]] : ~arr_rdata;
      // Programming can only clear bits
      if (arr_prog && !prog_q)
         mem[arr_addr[15:2]] <= mem[arr_addr[15:2]] & arr_wdata;
      if (arr_erase_page && !erase_q)
         for (int i = 0; i < 256; i++)
            mem[{arr_addr[15:10], i[7:0]}] <= 32'hFFFF_FFFF;
      if (arr_erase_mass && !mass_q)
         for (int i = 0; i < 16384; i++)
            mem[i] <= 32'hFFFF_FFFF;
      if (nv_commit) begin
         if (nv_commit_pe)
            nv_pe <= nv_commit_data;
         else
            nv_re <= nv_commit_data;
      end
   end
endmodule : flash_array_model

// [tb/flash_protect_program_ctrl_tb.sv]
`timescale 1ns/1ps
`include "flash_ctrl_consts.svh"
module flash_protect_program_ctrl_tb;
   logic clk, resetn, reg_wr, reg_rd, cpu_rd, cpu_fetch, cpu_rvalid, arr_rd, arr_prog;
   logic arr_erase_page, arr_erase_mass, nv_commit, nv_commit_pe, ctrl_irq, pe, re;
   logic [8:0] reg_addr;
   logic [15:0] cpu_addr, arr_raddr, arr_addr;
   logic [31:0] reg_wdata, reg_rdata, cpu_rdata, arr_rdata, arr_wdata, nv_pe, nv_re, nv_commit_data, v, d;
   logic [31:0] w [4];
   logic [7:0] rl;
   int err_total, n_compared, pcnt, ecnt;
   integer seed;
   flash_protect_program_ctrl flash_protect_program_ctrl_inst (.clk(clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cpu_rd(cpu_rd), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr), .cpu_rvalid(cpu_rvalid),
      .cpu_rdata(cpu_rdata), .arr_rd(arr_rd), .arr_raddr(arr_raddr), .arr_rdata(arr_rdata),
      .arr_prog(arr_prog), .arr_erase_page(arr_erase_page), .arr_erase_mass(arr_erase_mass),
      .arr_addr(arr_addr), .arr_wdata(arr_wdata), .nv_pe(nv_pe), .nv_re(nv_re), .nv_commit(nv_commit),
      .nv_commit_pe(nv_commit_pe), .nv_commit_data(nv_commit_data), .ctrl_irq(ctrl_irq));
   flash_array_model flash_array_model_inst (.clk(clk), .arr_rd(arr_rd), .arr_raddr(arr_raddr),
      .arr_rdata(arr_rdata), .arr_prog(arr_prog), .arr_erase_page(arr_erase_page),
      .arr_erase_mass(arr_erase_mass), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .nv_commit(nv_commit),
      .nv_commit_pe(nv_commit_pe), .nv_commit_data(nv_commit_data), .nv_pe(nv_pe), .nv_re(nv_re));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      if (arr_prog === 1'h1)
         pcnt++;
      if (arr_erase_page === 1'h1)
         ecnt++;
   end
   function automatic logic [31:0] f_pulse(input logic [7:0] r);
      // The pulse also stands through the cycle in which the timer reports done
      return {8'h00, `PROG_PULSE_US} * ({24'h00_0000, r} + 32'h0000_0001) + 32'h0000_0001;
   endfunction : f_pulse
   function automatic logic [15:0] base(input int k);
      return 16'h0800 * 16'(2 * k + 1);
   endfunction : base
   task automatic summarize;
      if (err_total == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
         err_total++;
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [31:0] dd);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= dd;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [8:0] a, output logic [31:0] dd);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      dd = reg_rdata;
   endtask : rd
   task automatic cread(input logic [15:0] a, input logic f, output logic [31:0] dd);
      dd = 'x;
      @(posedge clk);
      cpu_rd <= 1'h1;
      cpu_fetch <= f;
      cpu_addr <= a;
      @(posedge clk);
      cpu_rd <= 1'h0;
      for (int i = 0; i < 6; i++) begin
         #1;
         if (cpu_rvalid === 1'h1)
            dd = cpu_rdata;
         @(posedge clk);
      end
   endtask : cread
   task automatic op(input logic [3:0] c, input logic [15:0] a, input logic [31:0] dd, output logic [31:0] first);
      wr(`OFS_TARGET_ADDR, {16'h0000, a});
      wr(`OFS_WRITE_DATA, dd);
      pcnt = 0;
      ecnt = 0;
      wr(`OFS_COMMAND, {`WRITE_KEY, 12'h000, c});
      rd(`OFS_COMMAND, first);
      v = first;
      for (int i = 0; i < 15000 && v[3:0] != 4'h0; i++)
         rd(`OFS_COMMAND, v);
   endtask : op
   task automatic check_after_reset(input logic [31:0] pe_exp);
      rd(`OFS_TICK_RELOAD, v);
      chk("tick_reload", v, {24'h00_0000, `RST_TICK_RELOAD});
      rd(`OFS_PROG_PROTECT, v);
      chk("prog_enables", v, pe_exp);
      rd(`OFS_READ_PROTECT, v);
      chk("read_enables", v, `RST_PROTECT);
   endtask : check_after_reset
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      summarize;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'he8c2_200c;
      {resetn, reg_wr, reg_rd, cpu_rd, cpu_fetch} = 5'h00;
      reg_addr = 9'h000;
      reg_wdata = 32'h0000_0000;
      cpu_addr = 16'h0000;
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      check_after_reset(`RST_PROTECT);
      wr(`OFS_INT_MASK, 32'h0000_0001);
      for (int k = 0; k < 4; k++) begin
         rl = {6'h00, 2'($random(seed))};
         wr(`OFS_TICK_RELOAD, {24'h00_0000, rl});
         w[k] = $random(seed);
         op(4'h1, base(k), w[k], v);
         chk("prog_pulse", 32'(pcnt), f_pulse(rl));
      end
      // Units 1, 3, 5, 7 get open, read-only, no-read and execute-only policies
      wr(`OFS_PROG_PROTECT, 32'hFFFF_FF77);
      wr(`OFS_READ_PROTECT, 32'hFFFF_FF5F);
      wr(`OFS_PROG_PROTECT, 32'hFFFF_FFFF);
      wr(`OFS_READ_PROTECT, 32'hFFFF_FFFF);
      rd(`OFS_PROG_PROTECT, v);
      chk("prog_enables", v, 32'hFFFF_FF77);
      rd(`OFS_READ_PROTECT, v);
      chk("read_enables", v, 32'hFFFF_FF5F);
      for (int k = 0; k < 4; k++) begin
         pe = (k % 2) == 0;
         re = k < 2;
         rl = {6'h00, 2'($random(seed))};
         wr(`OFS_TICK_RELOAD, {24'h00_0000, rl});
         d = $random(seed);
         op(4'h1, base(k) + 16'h0004, d, v);
         chk("cmd_busy", {28'h000_0000, v[3:0]}, {31'h0000_0000, pe});
         chk("prog_pulse", 32'(pcnt), pe ? f_pulse(rl) : 32'h0000_0000);
         rd(`OFS_RAW_STATUS, v);
         chk("violation", {31'h0000_0000, v[0]}, {31'h0000_0000, !pe});
         chk("irq", {31'h0000_0000, ctrl_irq}, {31'h0000_0000, !pe});
         wr(`OFS_MASKED_STATUS, 32'h0000_0003);
         cread(base(k) + 16'h0004, 1'h1, v);
         chk("fetch_new", v, pe ? d : `ERASED_WORD);
         cread(base(k), 1'h0, v);
         chk("data_read", v, re ? w[k] : 32'h0000_0000);
         rd(`OFS_RAW_STATUS, v);
         chk("read_violation", {31'h0000_0000, v[0]}, {31'h0000_0000, !re});
         cread(base(k), 1'h1, v);
         chk("fetch_old", v, w[k]);
         wr(`OFS_MASKED_STATUS, 32'h0000_0003);
      end
      wr(`OFS_TICK_RELOAD, 32'h0000_0000);
      wr(`OFS_TARGET_ADDR, {16'h0000, base(0) + 16'h0008});
      wr(`OFS_COMMAND, 32'h5442_0001);
      rd(`OFS_COMMAND, v);
      chk("bad_key_cmd", {28'h000_0000, v[3:0]}, 32'h0000_0000);
      cread(base(0) + 16'h0008, 1'h1, v);
      chk("bad_key_data", v, `ERASED_WORD);
      d = $random(seed);
      op(4'h1, 16'h0C00, d, v);
      op(4'h2, base(0), 32'h0000_0000, v);
      chk("erase_pulse", 32'(ecnt), {8'h00, `PAGE_ERASE_US} + 32'h0000_0001);
      cread(base(0), 1'h1, v);
      chk("erased_word", v, `ERASED_WORD);
      cread(base(0) + 16'h0004, 1'h1, v);
      chk("erased_word", v, `ERASED_WORD);
      cread(16'h0C00, 1'h1, v);
      chk("other_page", v, d);
      cread(base(1), 1'h1, v);
      chk("other_unit", v, w[1]);
      op(4'h4, 16'h0000, 32'h0000_0000, v);
      chk("mass_cmd", {28'h000_0000, v[3:0]}, 32'h0000_0000);
      rd(`OFS_RAW_STATUS, v);
      chk("mass_violation", {31'h0000_0000, v[0]}, 32'h0000_0001);
      cread(16'h0C00, 1'h1, v);
      chk("mass_kept", v, d);
      wr(`OFS_TARGET_ADDR, 32'h0000_0001);
      wr(`OFS_COMMAND, {`WRITE_KEY, 16'h0008});
      repeat (4) @(posedge clk);
      resetn <= 1'h0;
      repeat (16) @(posedge clk);
      resetn <= 1'h1;
      repeat (4) @(posedge clk);
      check_after_reset(32'hFFFF_FF77);
      summarize;
   end
endmodule : flash_protect_program_ctrl_tb
